// >>> design/port_reset_ctl.sv
// Purpose: Root-port reset control and line-state readout
// Assumes: Line and high-speed inputs synchronous to clk
// Notes: Registers reached over AXI4-Lite; unmapped words answer SLVERR
//        A halted controller keeps a running bus reset going until port power is cleared
`timescale 1ns/1ps
`default_nettype none
module port_reset_ctl #(
  parameter int SETTLE = port_reset_pkg::SETTLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  // Register bus
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Line levels and controller status
  input  wire logic        dPlus,
  input  wire logic        dMinus,
  input  wire logic        highSpeedDetect,
  input  wire logic        controllerHalted,
  // Port controls
  output logic             busResetDrive,
  output logic             portEnable,
  output logic             portPower,
  output logic             portHandoffCompanion
);
  // Drive bus reset, then settle before the reset bit clears
  typedef enum logic [1:0] {
    IDLE     = 2'b00,
    DRIVING  = 2'b01,
    FINISHING = 2'b10
  } rst_state_t;

  rst_state_t  state;
  rst_state_t  next_state;
  logic [15:0] count;
  logic [15:0] next_count;
  logic        resetBit;
  logic        next_resetBit;
  logic        next_portEnable;
  logic        next_portPower;
  logic        next_portHandoffCompanion;

  // Bus slave holding registers
  logic        awHeld;
  logic        next_awHeld;
  logic [3:0]  awAddr;
  logic [3:0]  next_awAddr;
  logic        wHeld;
  logic        next_wHeld;
  logic [31:0] wData;
  logic [31:0] next_wData;
  logic [3:0]  wStrb;
  logic [3:0]  next_wStrb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        doWrite;
  logic        portWrite;
  logic [31:0] portRead;

  // Decoded writes and read index
  logic [3:0]  arIndex;
  logic [1:0]  lineStateField;
  logic        portFieldWr;
  logic        enableFieldWr;
  logic        resetWrOne;
  logic        resetWrZero;

  // Readies drop while a response waits, so one write is in flight
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite   = awHeld && wHeld && !s_axi_bvalid;
  assign portWrite = doWrite && awAddr == port_reset_pkg::PORTSC_OFFSET;

  // Any upper address bit set maps to an index no register uses
  assign arIndex = (s_axi_araddr[31:4] == 28'h0) ? s_axi_araddr[3:0] : 4'hF;
  assign lineStateField = {dPlus, dMinus};
  // Byte lane 1 carries reset, power and owner; lane 0 the enable bit
  assign portFieldWr   = portWrite && wStrb[1];
  assign enableFieldWr = portWrite && wStrb[0];
  assign resetWrOne    = portFieldWr && wData[port_reset_pkg::RESET_BIT];
  assign resetWrZero   = portFieldWr && !wData[port_reset_pkg::RESET_BIT];

  // Read image of the port register
  always_comb begin
    portRead = 32'h0;
    portRead[port_reset_pkg::ENABLE_BIT] = portEnable;
    // Power off forces the reset bit low on reads
    portRead[port_reset_pkg::RESET_BIT]  = resetBit && portPower;
    // D+ high bit, D- low bit; undefined content allowed when unpowered
    portRead[port_reset_pkg::LINE_HI_BIT] = lineStateField[1];
    portRead[port_reset_pkg::LINE_LO_BIT] = lineStateField[0];
    portRead[port_reset_pkg::POWER_BIT]   = portPower;
    portRead[port_reset_pkg::OWNER_BIT]   = portHandoffCompanion;
  end

  // Write channel: address and data taken in either order
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      // Upper address bits must be zero, else the word would alias a register
      next_awAddr = (s_axi_awaddr[31:4] == 28'h0) ? s_axi_awaddr[3:0] : 4'hF;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      if (awAddr == port_reset_pkg::PORTSC_OFFSET) begin
        next_bresp = port_reset_pkg::AXI_OKAY;
      end else begin
        // Unmapped or read-only word: nothing changes
        next_bresp = port_reset_pkg::AXI_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = port_reset_pkg::AXI_OKAY;
      case (arIndex)
        port_reset_pkg::PORTSC_OFFSET: begin
          next_rdata = portRead;
        end
        port_reset_pkg::STATUS_OFFSET: begin
          next_rdata = {30'h0, controllerHalted, highSpeedDetect};
        end
        default: begin
          next_rdata = 32'h0;
          next_rresp = port_reset_pkg::AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Port reset sequencer and port fields
  always_comb begin
    next_state                = state;
    next_count                = count;
    next_resetBit             = resetBit;
    next_portEnable           = portEnable;
    next_portPower            = portPower;
    next_portHandoffCompanion = portHandoffCompanion;

    // Software-written fields, gated by their byte lanes
    if (portFieldWr) begin
      next_portPower            = wData[port_reset_pkg::POWER_BIT];
      next_portHandoffCompanion = wData[port_reset_pkg::OWNER_BIT];
    end
    if (enableFieldWr) begin
      next_portEnable = wData[port_reset_pkg::ENABLE_BIT];
    end

    case (state)
      IDLE: begin
        // A one written while unpowered is dropped, not remembered
        if (resetWrOne && next_portPower) begin
          next_state    = DRIVING;
          next_resetBit = 1'b1;
          // Enable drops with reset even if software forgot to clear it
          next_portEnable = 1'b0;
        end
      end

      DRIVING: begin
        // While halted a zero write is ignored and the reset keeps going
        if (resetWrZero && !controllerHalted) begin
          next_state = FINISHING;
          next_count = 16'h0;
        end
        next_portEnable = 1'b0;
      end

      FINISHING: begin
        // Bit stays one until the settle period ends, well under 2 ms
        next_count      = count + 16'h1;
        next_portEnable = 1'b0;
        if (count >= 16'(SETTLE - 1)) begin
          next_state      = IDLE;
          next_resetBit   = 1'b0;
          // The sequencer takes the chirp result only here, once the bus is quiet; the status word reads it at any time
          next_portEnable = highSpeedDetect;
        end
      end

      default: begin
        next_state    = IDLE;
        next_resetBit = port_reset_pkg::RESET_DEFAULT;
      end
    endcase

    // Losing power abandons any reset in progress
    if (!next_portPower) begin
      next_state      = IDLE;
      next_resetBit   = 1'b0;
      next_portEnable = 1'b0;
    end
  end

  // Decoded from the state register, so it never glitches on bus activity
  assign busResetDrive = (state == DRIVING);

  // Port state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state                <= IDLE;
      count                <= 16'h0;
      resetBit             <= port_reset_pkg::RESET_DEFAULT;
      portEnable           <= 1'b0;
      portPower            <= 1'b0;
      portHandoffCompanion <= 1'b0;
    end else begin
      state                <= next_state;
      count                <= next_count;
      resetBit             <= next_resetBit;
      portEnable           <= next_portEnable;
      portPower            <= next_portPower;
      portHandoffCompanion <= next_portHandoffCompanion;
    end
  end

  // Write channel registers
  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld       <= 1'b0;
      awAddr       <= 4'h0;
      wHeld        <= 1'b0;
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      awHeld       <= next_awHeld;
      awAddr       <= next_awAddr;
      wHeld        <= next_wHeld;
      wData        <= next_wData;
      wStrb        <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
    end
  end

  // Read channel registers
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end
endmodule // port_reset_ctl
`default_nettype wire

// >>> design/port_reset_pkg.sv
// Purpose: Constants for the root-port reset and line-state block
// Assumes: 25 MHz clock, AXI4-Lite register access
// Notes: Register offsets are byte addresses
package port_reset_pkg;
  localparam logic [3:0] PORTSC_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET   = 4'h4;
  localparam int         ENABLE_BIT      = 2;
  localparam int         RESET_BIT       = 8;
  localparam int         LINE_LO_BIT     = 10;
  localparam int         LINE_HI_BIT     = 11;
  localparam int         POWER_BIT       = 12;
  localparam int         OWNER_BIT       = 13;
  localparam int         HS_BIT          = 0;
  localparam int         HALTED_BIT      = 1;
  localparam logic [1:0] LS_K_STATE      = 2'h1;
  localparam logic       RESET_DEFAULT   = 1'b0;
  localparam int         CLK_HZ          = 25000000;
  localparam int         FINISH_US       = 2000;
  localparam int         FINISH_CYCLES   = (CLK_HZ / 1000000) * FINISH_US;
  localparam int         SETTLE_US       = 1;
  localparam int         SETTLE_CYCLES   = (CLK_HZ / 1000000) * SETTLE_US;
  localparam logic [1:0] AXI_OKAY        = 2'h0;
  localparam logic [1:0] AXI_SLVERR      = 2'h2;
endpackage

// >>> verification/usb_device_model.sv
// Purpose: Downstream device on the root port
// Assumes: Host drives SE0 while bus reset is driven
// Notes: Chirp result latched during reset
`timescale 1ns/1ps
`default_nettype none
module usb_device_model (
  input  wire logic       clk,
  input  wire logic       busResetDrive,
  input  wire logic       portPower,
  input  wire logic [1:0] lineCode,
  input  wire logic       hsCapable,
  output logic            dPlus,
  output logic            dMinus,
  output logic            highSpeedDetect
);
  logic junk = 1'b0;
  initial highSpeedDetect = 1'b0;
  // Unpowered lines wander so no stale level looks valid
  always @(posedge clk) junk <= ~junk;
  always @(posedge clk) if (busResetDrive) highSpeedDetect <= hsCapable;
  assign dPlus  = !portPower ? junk : (busResetDrive ? 1'b0 : lineCode[1]);
  assign dMinus = !portPower ? ~junk : (busResetDrive ? 1'b0 : lineCode[0]);
endmodule // usb_device_model
`default_nettype wire

// >>> verification/port_reset_checker.sv
// Purpose: Port reset and line-state timing checks
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into port_reset_ctl
`timescale 1ns/1ps
`default_nettype none
module port_reset_checker #(parameter int SETTLE = 25) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        dPlus,
  input wire logic        dMinus,
  input wire logic        highSpeedDetect,
  input wire logic        controllerHalted,
  input wire logic        busResetDrive,
  input wire logic        portEnable,
  input wire logic        portPower
);
  localparam int FIN_HI = SETTLE + 4;
  logic wrCtl;
  logic rdCtl;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  assign wrCtl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr == 32'h0 && s_axi_wstrb[1];
  assign rdCtl = s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0;
  chk_reset_start: assert property (wrCtl && s_axi_wdata[8] && s_axi_wdata[12]
    |-> ##[1:2] busResetDrive) else $error("bus reset not started");
  chk_enable_low: assert property (busResetDrive |-> !portEnable)
    else $error("enable high in reset");
  chk_zero_ends: assert property (wrCtl && !s_axi_wdata[8] && !controllerHalted
    && busResetDrive |-> ##[1:2] !busResetDrive) else $error("reset not ended");
  chk_hs_enable: assert property ($fell(busResetDrive) && highSpeedDetect
    && portPower |-> ##[1:FIN_HI] portEnable) else $error("no auto enable");
  chk_fs_stays: assert property ($fell(busResetDrive) && !highSpeedDetect
    |-> ##FIN_HI !portEnable) else $error("enable set without high speed");
  chk_power_off: assert property (!portPower [*2] |-> !busResetDrive && !portEnable)
    else $error("reset while unpowered");
  chk_reset_clean: assert property ($fell(reset) |-> !busResetDrive && !portPower)
    else $error("bad state after reset");
  chk_halt_hold: assert property (controllerHalted && busResetDrive
    |=> busResetDrive || !portPower) else $error("reset dropped while halted");
  chk_line_read: assert property (portPower [*3] ##0 rdCtl
    |=> s_axi_rdata[11:10] == {$past(dPlus), $past(dMinus)}) else $error("line state wrong");
  chk_bit_busy: assert property (rdCtl && busResetDrive |=> s_axi_rdata[8])
    else $error("reset bit read zero");
  cover property ($fell(busResetDrive) && highSpeedDetect);
  cover property ($fell(busResetDrive) && !highSpeedDetect);
  cover property (controllerHalted && busResetDrive);
endmodule // port_reset_checker
bind port_reset_ctl port_reset_checker #(.SETTLE(SETTLE)) i_chk (.*);
`default_nettype wire

// >>> verification/usb_host_port_reset_linestate_bench.sv
// Purpose: Register-level test of port reset and line state
// Assumes: SETTLE shortened to 20 cycles
// Notes: Device model drives the lines
`timescale 1ns/1ps
`default_nettype none
module usb_host_port_reset_linestate_bench;
  logic clk = 1'b0, reset = 1'b1, controllerHalted = 1'b0, hsCapable = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, lineCode = 2'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic dPlus, dMinus, highSpeedDetect, busResetDrive, portEnable, portPower, portHandoffCompanion;
  int num_errors = 0, checks_done = 0;
  always #20 clk = ~clk;
  port_reset_ctl #(.SETTLE(20)) i_dut (.*);
  usb_device_model i_dev (.clk(clk), .busResetDrive(busResetDrive), .portPower(portPower),
    .lineCode(lineCode), .hsCapable(hsCapable), .dPlus(dPlus), .dMinus(dMinus),
    .highSpeedDetect(highSpeedDetect));
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    check({30'h0, s_axi_bresp},
          {30'h0, (a == 32'h0) ? port_reset_pkg::AXI_OKAY : port_reset_pkg::AXI_SLVERR});
    s_axi_bready <= 1'b0;
    @(posedge clk);
    if (n == 40) check(32'h0, 32'h1);
    if (n == 40) results;
  endtask
  task automatic readCheck(input logic [31:0] a, m, e, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    check({30'h0, s_axi_rresp}, {30'h0, er});
    check(rd & m, e);
    @(posedge clk);
    if (n == 40) check(32'h0, 32'h1);
    if (n == 40) results;
  endtask
  initial begin
    int n;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    readCheck(32'h0, 32'h3104, 32'h0, port_reset_pkg::AXI_OKAY);
    axiWrite(32'h0, 32'h1000);
    for (int c = 0; c < 4; c++) begin
      lineCode <= c[1:0];
      readCheck(32'h0, 32'h0C00, {20'h0, c[1:0], 10'h0}, port_reset_pkg::AXI_OKAY);
      // K-state means low speed: give the port away instead of resetting
      axiWrite(32'h0, (c == 1) ? 32'h3000 : 32'h1000);
      check({31'h0, portHandoffCompanion}, 32'(c == 1));
    end
    $display("line state test done");
    lineCode <= 2'h2;
    for (int h = 1; h >= 0; h--) begin
      hsCapable <= h[0];
      axiWrite(32'h0, 32'h1100);
      check({31'h0, busResetDrive}, 32'h1);
      readCheck(32'h0, 32'h0104, 32'h0100, port_reset_pkg::AXI_OKAY);
      axiWrite(32'h0, 32'h1000);
      check({31'h0, busResetDrive}, 32'h0);
      readCheck(32'h0, 32'h0100, 32'h0100, port_reset_pkg::AXI_OKAY);
      for (n = 0; n < 10 && rd[8]; n++) readCheck(32'h0, 32'h0, 32'h0, port_reset_pkg::AXI_OKAY);
      check(rd & 32'h0104, h ? 32'h4 : 32'h0);
    end
    $display("reset sequence test done");
    controllerHalted <= 1'b1;
    axiWrite(32'h0, 32'h1100);
    axiWrite(32'h0, 32'h1000);
    repeat (30) @(posedge clk);
    readCheck(32'h0, 32'h0100, 32'h0100, port_reset_pkg::AXI_OKAY);
    readCheck(32'h4, 32'h2, 32'h2, port_reset_pkg::AXI_OKAY);
    axiWrite(32'h0, 32'h0100);
    readCheck(32'h0, 32'h1104, 32'h0, port_reset_pkg::AXI_OKAY);
    controllerHalted <= 1'b0;
    $display("halt and power test done");
    axiWrite(32'h8, 32'h1000);
    readCheck(32'h8, 32'hFFFFFFFF, 32'h0, port_reset_pkg::AXI_SLVERR);
    readCheck(32'h0, 32'h1000, 32'h0, port_reset_pkg::AXI_OKAY);
    $display("unmapped test done");
    results;
  end
endmodule // usb_host_port_reset_linestate_bench
`default_nettype wire
